// [nvm_pkg.sv]
// package: control register layout, offsets and reset values for the eeprom control block
package nvm_pkg;
    localparam logic [7:0] ctrl_offset = 8'h07;
    localparam logic [7:0] ctrl_reset = 8'h00;
    localparam int bit_irq_en = 7;
    localparam int bit_sleep = 6;
    localparam int bit_clk_out = 3;
    localparam int bit_erase = 2;
    localparam int bit_latch = 1;
    localparam int bit_pump = 0;
    localparam int array_bytes = 256;
    localparam logic [7:0] protect_base = 8'h20;
    localparam logic [7:0] erased_value = 8'hFF;
    localparam logic [7:0] array_reset_addr = 8'h00;
    typedef enum logic [1:0] {op_idle, op_armed, op_active} op_e;
endpackage : nvm_pkg

// [nvm_array.sv]
// byte-wide nonvolatile array model with registered read data
`timescale 1ns/100ps
`default_nettype none
module nvm_array #(
    parameter int depth = 256
) (
    input wire logic sys_clk,
    input wire logic [7:0] addr,
    input wire logic wr_en,
    input wire logic clr_en,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] mem [depth];

    // the address bus is eight bits wide, so only the full array can be served
    if (depth != 256) begin : g_depth_check
        $error("array depth must be 256");
    end

    // program only pulls bits low, erase sets the whole byte high
    always_ff @(posedge sys_clk) begin
        if (clr_en) begin
            mem[addr] <= 8'hFF;
        end else if (wr_en) begin
            mem[addr] <= mem[addr] & wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        rdata <= mem[addr];
    end
endmodule : nvm_array
`default_nettype wire

// [nvm_ctrl.sv]
// eeprom byte program/erase control register and sequencing
`timescale 1ns/100ps
`default_nettype none
// How it works
// RULE_01 - eight-bit control register, resets to zero
// RULE_02 - irq enable only if fitted, cleared
// RULE_03 - sleep flag follows can controller state
// RULE_04 - latch plus pump: erase or program
// RULE_05 - erase select frozen after address latch
// RULE_06 - latch captures write; no latch reads
// RULE_07 - stop and resets clear latch
// RULE_08 - pump bit drives high voltage
// RULE_09 - pump needs latched data, sticky
// RULE_10 - three-bit mode decode
// RULE_11 - read mode returns stored bytes
// RULE_12 - reads under latch return ff
// RULE_13 - software erase sequence order
// RULE_14 - array inaccessible during erase
// RULE_15 - erased ff, programmed 00
// RULE_16 - erase latches address, ignores data
// RULE_17 - new addresses ignored while latched
// RULE_18 - software runs outside array when latched
// RULE_19 - single-byte erase only
// RULE_20 - idle in read mode recommended
// RULE_21 - software program sequence order
// RULE_22 - protect blocks upper 224 bytes
// RULE_23 - stop returns to read, pump off
// RULE_24 - no internal timer; pump until unlatched
module nvm_ctrl #(
    parameter bit irq_option_fitted = 1'b1
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic por,
    input wire logic stop_entry,
    input wire logic can_sleep_in,
    input wire logic upper_region_protect,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] arr_addr,
    input wire logic [7:0] arr_wdata,
    input wire logic arr_wr,
    input wire logic arr_rd,
    output logic [7:0] arr_rdata,
    output logic pump_voltage_pin,
    output logic wired_or_irq_enable,
    output logic bus_clock_out_option
);
    logic erase_select;
    logic latch_enable;
    logic pump_on;
    logic can_sleep_flag;
    logic sleep_s1;
    logic sleep_s2;
    logic addr_latched;
    logic [7:0] held_addr;
    logic [7:0] held_data;
    logic apply_hv;
    logic ctrl_wr;
    logic clear_latch;
    logic rd_arr_q;
    logic rd_reg_q;
    logic latch_at_rd;
    logic [7:0] mem_q;
    logic [7:0] ctrl_value;
    logic in_region_ok;
    logic pulse_done;
    logic arr_set;
    logic arr_clr;
    nvm_pkg::op_e mode;

    assign ctrl_wr = reg_wr && reg_addr == nvm_pkg::ctrl_offset;
    assign clear_latch = stop_entry || por; // rst handled in each process [RULE_07] [RULE_23]

    // can sleep indication passes two flops from the other block
    always_ff @(posedge sys_clk) begin
        sleep_s1 <= can_sleep_in;
        sleep_s2 <= sleep_s1;
    end

    always_ff @(posedge sys_clk) begin
        if (rst || por) begin
            can_sleep_flag <= 1'b0; // [RULE_01]
        end else begin
            can_sleep_flag <= sleep_s2; // [RULE_03]
        end
    end

    // irq enable is cleared by power-on and by reset; forced low without the option
    always_ff @(posedge sys_clk) begin
        if (por) begin
            wired_or_irq_enable <= 1'b0; // [RULE_02]
        end else if (rst) begin
            wired_or_irq_enable <= 1'b0; // [RULE_01]
        end else if (ctrl_wr) begin
            wired_or_irq_enable <= reg_wdata[nvm_pkg::bit_irq_en] & irq_option_fitted; // [RULE_02]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || por) begin
            bus_clock_out_option <= 1'b0; // [RULE_01]
        end else if (ctrl_wr) begin
            bus_clock_out_option <= reg_wdata[nvm_pkg::bit_clk_out];
        end
    end

    // latch, erase select and pump; clearing latch clears the other two
    always_ff @(posedge sys_clk) begin
        if (rst || clear_latch) begin
            latch_enable <= 1'b0; // [RULE_07] [RULE_23]
            erase_select <= 1'b0;
            pump_on <= 1'b0;
        end else if (ctrl_wr) begin
            latch_enable <= reg_wdata[nvm_pkg::bit_latch];
            if (!reg_wdata[nvm_pkg::bit_latch]) begin
                erase_select <= 1'b0; // [RULE_06]
                pump_on <= 1'b0; // [RULE_09] [RULE_24]
            end else begin
                if (!addr_latched) begin
                    erase_select <= reg_wdata[nvm_pkg::bit_erase]; // [RULE_05]
                end
                // pump only after address/data latched; once on it stays on
                if (addr_latched && latch_enable) begin
                    pump_on <= pump_on | reg_wdata[nvm_pkg::bit_pump]; // [RULE_09]
                end
            end
        end
    end

    // capture first array write while latched and pump off; later writes ignored
    always_ff @(posedge sys_clk) begin
        if (rst || clear_latch || (ctrl_wr && !reg_wdata[nvm_pkg::bit_latch])) begin
            addr_latched <= 1'b0;
            held_addr <= nvm_pkg::array_reset_addr;
            held_data <= nvm_pkg::erased_value;
        end else if (arr_wr && latch_enable && !pump_on && !addr_latched) begin
            addr_latched <= 1'b1; // [RULE_06] [RULE_17]
            held_addr <= arr_addr;
            held_data <= erase_select ? nvm_pkg::erased_value : arr_wdata; // [RULE_16]
        end
    end

    // protected upper region refuses erase and program
    assign in_region_ok = upper_region_protect || held_addr < nvm_pkg::protect_base; // [RULE_22]

    // mode as the array sees it; pump without latch cannot occur and falls to idle
    always_comb begin
        unique case ({latch_enable, pump_on})
            2'h2: mode = nvm_pkg::op_armed; // [RULE_10]
            2'h3: mode = nvm_pkg::op_active; // [RULE_10]
            default: mode = nvm_pkg::op_idle;
        endcase
    end

    // high voltage stays on with pump bit; no internal timer
    assign apply_hv = mode == nvm_pkg::op_active; // [RULE_04] [RULE_10] [RULE_24]
    assign pump_voltage_pin = pump_on; // [RULE_08]

    // the array changes once per operation: a one-shot keeps the effect single-byte
    always_ff @(posedge sys_clk) begin
        if (rst || !apply_hv) begin
            pulse_done <= 1'b0;
        end else begin
            pulse_done <= 1'b1;
        end
    end

    // one array strobe per operation, steered by the erase select bit
    assign arr_set = apply_hv && !pulse_done && !erase_select && in_region_ok; // [RULE_04]
    assign arr_clr = apply_hv && !pulse_done && erase_select && in_region_ok; // [RULE_19]

    nvm_array #(
        .depth(nvm_pkg::array_bytes)
    ) u_array (
        .sys_clk(sys_clk),
        .addr(latch_enable ? held_addr : arr_addr), // array bus latched [RULE_18]
        .wr_en(arr_set), // program pulls bits low [RULE_15]
        .clr_en(arr_clr), // erase sets the whole byte [RULE_15]
        .wdata(held_data),
        .rdata(mem_q)
    );

    // read side: one-cycle latency, ff while latched
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_arr_q <= 1'b0;
            latch_at_rd <= 1'b0;
            rd_reg_q <= 1'b0;
        end else begin
            rd_arr_q <= arr_rd;
            latch_at_rd <= latch_enable;
            rd_reg_q <= reg_rd;
        end
    end

    always_comb begin
        if (!rd_arr_q) begin
            arr_rdata = 8'h00;
        end else if (latch_at_rd) begin
            arr_rdata = nvm_pkg::erased_value; // [RULE_12] [RULE_14]
        end else begin
            arr_rdata = mem_q; // [RULE_11]
        end
    end

    always_comb begin
        ctrl_value = nvm_pkg::ctrl_reset;
        ctrl_value[nvm_pkg::bit_irq_en] = wired_or_irq_enable;
        ctrl_value[nvm_pkg::bit_sleep] = can_sleep_flag;
        ctrl_value[nvm_pkg::bit_clk_out] = bus_clock_out_option;
        ctrl_value[nvm_pkg::bit_erase] = erase_select;
        ctrl_value[nvm_pkg::bit_latch] = latch_enable;
        ctrl_value[nvm_pkg::bit_pump] = pump_on; // [RULE_01]
    end

    // register read data, zero for unmapped addresses
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= nvm_pkg::ctrl_reset;
        end else if (reg_rd && reg_addr == nvm_pkg::ctrl_offset) begin
            reg_rdata <= ctrl_value;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // checks on the control bits, the capture latch and the array strobes
    property p_unlatched_clear;
        @(posedge sys_clk) disable iff (rst) !latch_enable |-> !pump_on && !erase_select;
    endproperty
    a_unlatched_clear: assert property (p_unlatched_clear) // [RULE_06]
        else $error("pump/erase set without latch");

    property p_pump_needs_addr;
        @(posedge sys_clk) disable iff (rst) $rose(pump_on) |-> $past(addr_latched);
    endproperty
    a_pump_needs_addr: assert property (p_pump_needs_addr) // [RULE_09]
        else $error("pump set before latch");

    property p_pump_sticky;
        @(posedge sys_clk) disable iff (rst) $fell(pump_on) |-> !latch_enable;
    endproperty
    a_pump_sticky: assert property (p_pump_sticky) // [RULE_09]
        else $error("pump cleared alone");

    property p_erase_frozen;
        @(posedge sys_clk) disable iff (rst) addr_latched && $past(addr_latched) && latch_enable
            |-> $stable(erase_select);
    endproperty
    a_erase_frozen: assert property (p_erase_frozen) // [RULE_05]
        else $error("erase select changed");

    property p_stop_clears;
        @(posedge sys_clk) disable iff (rst) stop_entry |=> !latch_enable && !pump_on;
    endproperty
    a_stop_clears: assert property (p_stop_clears) // [RULE_07]
        else $error("stop did not clear");

    property p_read_ff;
        @(posedge sys_clk) disable iff (rst) arr_rd && latch_enable |=> arr_rdata == 8'hFF;
    endproperty
    a_read_ff: assert property (p_read_ff) // [RULE_12]
        else $error("latched read not ff");

    property p_pump_on_write;
        @(posedge sys_clk) disable iff (rst) $rose(pump_voltage_pin)
            |-> $past(ctrl_wr) && $past(reg_wdata[nvm_pkg::bit_pump]);
    endproperty
    a_pump_on_write: assert property (p_pump_on_write) // [RULE_08]
        else $error("pump pin rose without a control write");

    property p_no_irq_unfitted;
        @(posedge sys_clk) disable iff (rst) !irq_option_fitted |-> !wired_or_irq_enable;
    endproperty
    a_no_irq_unfitted: assert property (p_no_irq_unfitted) // [RULE_02]
        else $error("irq enable unfitted");

    property p_rdata_idle;
        @(posedge sys_clk) disable iff (rst) !rd_reg_q |-> reg_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) // [RULE_01]
        else $error("register read data outside the read cycle");

    property p_unused_bits;
        @(posedge sys_clk) disable iff (rst) reg_rdata[5:4] == 2'h0;
    endproperty
    a_unused_bits: assert property (p_unused_bits) // [RULE_01]
        else $error("bits 5 and 4 not zero");

    property p_irq_por;
        @(posedge sys_clk) disable iff (rst) por |=> !wired_or_irq_enable;
    endproperty
    a_irq_por: assert property (p_irq_por) // [RULE_02]
        else $error("irq enable survived power-on");

    property p_sleep_follows;
        @(posedge sys_clk) disable iff (rst) !$past(rst) && !$past(por)
            |-> can_sleep_flag == $past(sleep_s2);
    endproperty
    a_sleep_follows: assert property (p_sleep_follows) // [RULE_03]
        else $error("sleep flag does not follow the controller");

    property p_pump_rise_array;
        @(posedge sys_clk) disable iff (rst) $rose(pump_on) && in_region_ok |-> arr_set || arr_clr;
    endproperty
    a_pump_rise_array: assert property (p_pump_rise_array) // [RULE_04]
        else $error("pump rose without an array strobe");

    property p_clear_kind;
        @(posedge sys_clk) disable iff (rst) arr_clr |-> erase_select && latch_enable && pump_on;
    endproperty
    a_clear_kind: assert property (p_clear_kind) // [RULE_10]
        else $error("array erased outside erase mode");

    property p_latch_write;
        @(posedge sys_clk) disable iff (rst) ctrl_wr && !clear_latch
            |=> latch_enable == $past(reg_wdata[nvm_pkg::bit_latch]);
    endproperty
    a_latch_write: assert property (p_latch_write) // [RULE_06]
        else $error("latch bit did not take the write");

    property p_no_capture_under_hv;
        @(posedge sys_clk) disable iff (rst) arr_wr && pump_on && !ctrl_wr && !clear_latch
            |=> $stable(held_addr);
    endproperty
    a_no_capture_under_hv: assert property (p_no_capture_under_hv) // [RULE_14]
        else $error("array write taken under high voltage");

    property p_erase_data_ignored;
        @(posedge sys_clk) disable iff (rst) $rose(addr_latched) && $past(erase_select)
            |-> held_data == nvm_pkg::erased_value;
    endproperty
    a_erase_data_ignored: assert property (p_erase_data_ignored) // [RULE_16]
        else $error("erase kept written data");

    property p_capture_once;
        @(posedge sys_clk) disable iff (rst) addr_latched && $past(addr_latched)
            |-> $stable(held_addr);
    endproperty
    a_capture_once: assert property (p_capture_once) // [RULE_17]
        else $error("held address changed while latched");

    property p_single_write;
        @(posedge sys_clk) disable iff (rst) arr_set || arr_clr |=> !arr_set && !arr_clr;
    endproperty
    a_single_write: assert property (p_single_write) // [RULE_19]
        else $error("array strobed twice in one operation");

    property p_protect_upper;
        @(posedge sys_clk) disable iff (rst) (arr_set || arr_clr) && !upper_region_protect
            |-> held_addr < nvm_pkg::protect_base;
    endproperty
    a_protect_upper: assert property (p_protect_upper) // [RULE_22]
        else $error("protected byte changed");

    property p_hv_until_unlatch;
        @(posedge sys_clk) disable iff (rst) $past(pump_on) && latch_enable |-> pump_on;
    endproperty
    a_hv_until_unlatch: assert property (p_hv_until_unlatch) // [RULE_24]
        else $error("pump dropped while latched");
endmodule : nvm_ctrl
`default_nettype wire

// [cpu_bus_model.sv]
// cpu core model: register and array bus master for the write software
`timescale 1ns/100ps
`default_nettype none
module cpu_bus_model (
    input wire logic sys_clk,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] arr_rdata,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] arr_addr,
    output logic [7:0] arr_wdata,
    output logic arr_wr,
    output logic arr_rd
);
    // bus idle from time zero; code runs from ram, never fetches the array
    initial begin
        {reg_addr, reg_wdata, arr_addr, arr_wdata} = 32'h0000_0000;
        {reg_wr, reg_rd, arr_wr, arr_rd} = 4'h0;
    end
    // one strobe cycle; data lines flip afterwards so a stale value never looks held
    task automatic xfer(input bit arr, input bit wr, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        @(posedge sys_clk);
        reg_addr <= a;
        arr_addr <= a;
        reg_wdata <= d;
        arr_wdata <= d;
        {arr_wr, arr_rd, reg_wr, reg_rd} <= {arr & wr, arr & !wr, !arr & wr, !arr & !wr};
        @(posedge sys_clk);
        {arr_wr, arr_rd, reg_wr, reg_rd} <= 4'h0;
        reg_wdata <= ~d;
        arr_wdata <= ~d;
        #1 q = arr ? arr_rdata : reg_rdata; // read data stand only in this cycle
    endtask : xfer
endmodule : cpu_bus_model
`default_nettype wire

// [test_eeprom_byte_program_erase_control.sv]
// self-checking bench for the nonvolatile write control block
`timescale 1ns/100ps
`default_nettype none
module test_eeprom_byte_program_erase_control;
    localparam int program_time = 6; // any length: the block never times the pulse
    logic sys_clk, rst, por, stop_entry, can_sleep_in, upper_region_protect;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, arr_addr, arr_wdata, arr_rdata, q;
    logic reg_wr, reg_rd, arr_wr, arr_rd, pump_voltage_pin, wired_or_irq_enable;
    logic bus_clock_out_option, unfit_irq;
    int fail_count = 0;
    int checks = 0;
    nvm_ctrl #(.irq_option_fitted(1'b1)) i_dut (.sys_clk(sys_clk), .rst(rst), .por(por),
        .stop_entry(stop_entry), .can_sleep_in(can_sleep_in),
        .upper_region_protect(upper_region_protect), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_wr(arr_wr), .arr_rd(arr_rd),
        .arr_rdata(arr_rdata), .pump_voltage_pin(pump_voltage_pin),
        .wired_or_irq_enable(wired_or_irq_enable), .bus_clock_out_option(bus_clock_out_option));
    cpu_bus_model i_cpu (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .arr_rdata(arr_rdata),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_wr(arr_wr), .arr_rd(arr_rd));
    // same stimulus into a build without the wake interrupt option
    nvm_ctrl #(.irq_option_fitted(1'b0)) i_dut_unfit (.sys_clk(sys_clk), .rst(rst), .por(por),
        .stop_entry(stop_entry), .can_sleep_in(can_sleep_in),
        .upper_region_protect(upper_region_protect), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(),
        .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_wr(arr_wr), .arr_rd(arr_rd),
        .arr_rdata(), .pump_voltage_pin(), .wired_or_irq_enable(unfit_irq),
        .bus_clock_out_option());
    // byte compare, counted
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // short bus helpers
    task automatic wc(input logic [7:0] d);
        i_cpu.xfer(1'b0, 1'b1, nvm_pkg::ctrl_offset, d, q);
    endtask : wc
    task automatic cc(input logic [7:0] e);
        i_cpu.xfer(1'b0, 1'b0, nvm_pkg::ctrl_offset, 8'h00, q);
        chk("ctrl", e, q);
    endtask : cc
    task automatic wa(input logic [7:0] a, input logic [7:0] d);
        i_cpu.xfer(1'b1, 1'b1, a, d, q);
    endtask : wa
    task automatic ca(input logic [7:0] a, input logic [7:0] e);
        i_cpu.xfer(1'b1, 1'b0, a, 8'h00, q);
        chk("array byte", e, q);
    endtask : ca
    task automatic cp(input logic e);
        chk("pump pin", {7'h00, e}, {7'h00, pump_voltage_pin});
    endtask : cp
    // plain bits stick; erase and pump refused while unlatched; power-on clears all
    task automatic t_bits();
        wc(8'h8D);
        cc(8'h88);
        chk("irq clk", 8'h03, {6'h00, wired_or_irq_enable, bus_clock_out_option});
        chk("unfitted irq", 8'h00, {7'h00, unfit_irq});
        i_cpu.xfer(1'b0, 1'b1, 8'h06, 8'h00, q);
        cc(8'h88);
        wc(8'h83);
        cc(8'h82);
        @(posedge sys_clk) por <= 1'b1;
        @(posedge sys_clk) por <= 1'b0;
        cc(8'h00);
    endtask : t_bits
    // sleep flag follows the synchronised input both ways
    task automatic t_sleep();
        @(posedge sys_clk) can_sleep_in <= 1'b1;
        repeat (5) @(posedge sys_clk);
        cc(8'h40);
        @(posedge sys_clk) can_sleep_in <= 1'b0;
        repeat (5) @(posedge sys_clk);
        cc(8'h00);
    endtask : t_sleep
    // erase with zero data written; select frozen, pump sticky until unlatched
    task automatic t_erase(input logic [7:0] a, input logic [7:0] e);
        wc(8'h06);
        wa(a, 8'h00);
        wc(8'h03);
        cc(8'h07);
        cp(1'b1);
        wa(a ^ 8'h01, 8'h00);
        ca(a, 8'hFF);
        wc(8'h02);
        cc(8'h07);
        wc(8'h00);
        cp(1'b0);
        ca(a, e);
    endtask : t_erase
    // program a, then try a second address while still latched
    task automatic t_prog(input logic [7:0] a, input logic [7:0] d, input logic [7:0] b);
        wc(8'h02);
        wa(a, d);
        wa(b, 8'h00);
        wc(8'h03);
        cc(8'h03);
        ca(a, 8'hFF);
        repeat (program_time) @(posedge sys_clk);
        wc(8'h00);
        cc(8'h00);
    endtask : t_prog
    // stop or reset in mid-operation drops latch and pump
    task automatic t_halt(input bit use_rst);
        wc(8'h02);
        wa(8'h07, 8'h00);
        wc(8'h03);
        cp(1'b1);
        @(posedge sys_clk) {rst, stop_entry} <= {use_rst, !use_rst};
        @(posedge sys_clk) {rst, stop_entry} <= 2'h0;
        cc(8'h00);
        cp(1'b0);
    endtask : t_halt
    // verdict and end of run
    task automatic close_out();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out
    // 50 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // main sequence; array contents are unknown until erased
    initial begin
        {rst, por, stop_entry, can_sleep_in} = 4'h8;
        upper_region_protect = 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        cc(8'h00);
        cp(1'b0);
        t_bits();
        t_sleep();
        t_erase(8'h05, 8'hFF);
        t_erase(8'h06, 8'hFF);
        t_prog(8'h05, 8'h5A, 8'h06);
        ca(8'h05, 8'h5A);
        ca(8'h06, 8'hFF);
        t_prog(8'h06, 8'h3C, 8'h05);
        ca(8'h05, 8'h5A);
        t_erase(8'h05, 8'hFF);
        ca(8'h06, 8'h3C);
        t_erase(8'h20, 8'hFF);
        t_prog(8'h20, 8'h00, 8'h21);
        @(posedge sys_clk) upper_region_protect <= 1'b0;
        t_erase(8'h20, 8'h00);
        t_erase(8'h1F, 8'hFF);
        t_halt(1'b0);
        t_halt(1'b1);
        close_out();
    end
endmodule : test_eeprom_byte_program_erase_control
`default_nettype wire
